// *** pkg/occ_pkg.sv ***
// Package: offsets, fields and encodings of the offset corrector control bank
package occ_pkg;
  // Byte addresses on the register bus (two channel pages side by side)
  localparam logic [11:0] OCC_CTRL_OFFSET = 12'h0068;
  localparam logic [11:0] OCC_PAGE_A = 12'h0000;
  localparam logic [11:0] OCC_PAGE_B = 12'h0100;
  localparam logic [11:0] OCC_ADDR_CH_A = 12'h0068;
  localparam logic [11:0] OCC_ADDR_CH_B = 12'h0168;
  // Field positions
  localparam int OCC_BIT_FREEZE = 7;
  localparam int OCC_BIT_KEEP_HI = 5;
  localparam int OCC_BIT_BYPASS = 2;
  localparam int OCC_BIT_KEEP_LO = 1;
  // Reset value and storable bits
  localparam logic [7:0] OCC_CTRL_RESET = 8'h00;
  localparam logic [7:0] OCC_CTRL_MASK = 8'hA7;
  // Control patterns {bit7, bit5, bit1}
  localparam logic [2:0] OCC_PAT_RUN = 3'h3;
  localparam logic [2:0] OCC_PAT_FREEZE = 3'h7;
  // Bus responses
  localparam logic [1:0] OCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] OCC_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    OCC_MODE_OFF,
    OCC_MODE_RUN,
    OCC_MODE_FREEZE
  } occ_mode_t;
endpackage

// *** design/occ_chan.sv ***
// One channel's control decode: register byte to corrector mode
`timescale 1ns/1ps
module occ_chan (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register value
  input wire logic [7:0] ctrl,
  // Corrector controls
  output occ_pkg::occ_mode_t mode,
  output logic estimate_en,
  output logic bypass_corrector
);
  import occ_pkg::*;
  logic [2:0] pattern;
  occ_mode_t mode_ff, nxt_mode;
  logic est_ff, nxt_est;
  logic byp_ff, nxt_byp;

  always_comb begin
    pattern = {ctrl[OCC_BIT_FREEZE], ctrl[OCC_BIT_KEEP_HI], ctrl[OCC_BIT_KEEP_LO]};
    nxt_byp = ctrl[OCC_BIT_BYPASS];
    if (nxt_byp) begin
      nxt_mode = OCC_MODE_OFF;
    end else if (pattern == OCC_PAT_FREEZE) begin
      nxt_mode = OCC_MODE_FREEZE;
    end else begin
      nxt_mode = OCC_MODE_RUN;
    end
    // Freeze stops estimation; the held correction keeps being applied
    nxt_est = (nxt_mode == OCC_MODE_RUN);
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mode_ff <= OCC_MODE_RUN;
      est_ff <= 1'b1;
      byp_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      est_ff <= nxt_est;
      byp_ff <= nxt_byp;
    end
  end

  assign mode = mode_ff;
  assign estimate_en = est_ff;
  assign bypass_corrector = byp_ff;
endmodule

// *** design/occ_ctrl_top.sv ***
// Offset corrector control bank for two channels behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Function
// - Pattern 111 with bit 2 clear stops estimation and keeps applying the last correction.
// - Pattern is bit 7, then bit 5, then bit 1 as LSB.
// - Bypass clear runs corrector, suppressing fs/8, fs/4, 3fs/8, fs/2 spurs.
// - Channel B has an identical, independent register at offset_corrector_ctrl_ch_a of its page.
module occ_ctrl_top (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel A corrector controls
  output occ_pkg::occ_mode_t mode_ch_a,
  output logic estimate_en_ch_a,
  output logic bypass_corrector_ch_a,
  // Channel B corrector controls
  output occ_pkg::occ_mode_t mode_ch_b,
  output logic estimate_en_ch_b,
  output logic bypass_corrector_ch_b
);
  import occ_pkg::*;

  // Register bank, one byte per channel page
  logic [7:0] ctrl_ff [2];
  logic [7:0] nxt_ctrl [2];

  // Write halves captured on their own, plus the response
  logic aw_ff, nxt_aw;
  logic [11:0] awaddr_ff, nxt_awaddr;
  logic w_ff, nxt_w;
  logic [7:0] wdata_ff, nxt_wdata;
  logic wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;

  // Read answer
  logic rvalid_ff, nxt_rvalid;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;

  // Registered readies
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic arready_ff, nxt_arready;

  // Write strobe and page select
  logic do_write;
  logic [1:0] wsel;

  // Per-channel decoder outputs
  occ_mode_t chan_mode [2];
  logic chan_est [2];
  logic chan_byp [2];

  // Write path: address and data latched independently, in either order
  always_comb begin
    nxt_aw = aw_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w = w_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_ctrl = ctrl_ff;
    if (s_axi_awvalid && awready_ff) begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    // Only byte lane 0 carries a register; upper lanes are ignored
    if (s_axi_wvalid && wready_ff) begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata[7:0];
      nxt_wstrb = s_axi_wstrb[0];
    end
    do_write = aw_ff && w_ff && !bvalid_ff;
    wsel = {awaddr_ff == OCC_ADDR_CH_B, awaddr_ff == OCC_ADDR_CH_A};
    if (do_write) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (wsel != 2'h0) ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
      for (int i = 0; i < 2; i++) begin
        // Only bits 7, 5, 2, 1 and 0 are stored; the other bits always read back zero
        if (wsel[i] && wstrb_ff) begin
          nxt_ctrl[i] = wdata_ff & OCC_CTRL_MASK;
        end
      end
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // Read path: one cycle from address to data
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    if (s_axi_arvalid && arready_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = OCC_RESP_OKAY;
      if (s_axi_araddr == OCC_ADDR_CH_A) begin
        nxt_rdata = {24'h00_0000, ctrl_ff[0]};
      end else if (s_axi_araddr == OCC_ADDR_CH_B) begin
        nxt_rdata = {24'h00_0000, ctrl_ff[1]};
      end else begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = OCC_RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  // Ready group: each ready is a register, so it drops on the same edge that takes its half
  always_comb begin
    // One write in flight: stop taking halves until the response drains
    nxt_awready = !nxt_aw && !nxt_bvalid;
    nxt_wready = !nxt_w && !nxt_bvalid;
    // A read waits until its data has been accepted
    nxt_arready = !nxt_rvalid;
  end

  // Write group and register bank
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_ff[0] <= OCC_CTRL_RESET;
      ctrl_ff[1] <= OCC_CTRL_RESET;
      aw_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      w_ff <= 1'b0;
      wdata_ff <= 8'h00;
      wstrb_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      aw_ff <= nxt_aw;
      awaddr_ff <= nxt_awaddr;
      w_ff <= nxt_w;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
    end
  end

  // Read group
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= 2'h0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
    end
  end

  // Readies stay low in reset so nothing is taken before release
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      arready_ff <= 1'b0;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      arready_ff <= nxt_arready;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Per-channel decode; patterns other than 011/111 are treated as running
  for (genvar g = 0; g < 2; g++) begin : g_chan
    occ_chan u_chan (
      .clock(clock),
      .sys_rst(sys_rst),
      .ctrl(ctrl_ff[g]),
      .mode(chan_mode[g]),
      .estimate_en(chan_est[g]),
      .bypass_corrector(chan_byp[g])
    );
  end
  // Page B carries the same fields and acts only on channel B
  assign mode_ch_a = chan_mode[0];
  assign estimate_en_ch_a = chan_est[0];
  assign bypass_corrector_ch_a = chan_byp[0];
  assign mode_ch_b = chan_mode[1];
  assign estimate_en_ch_b = chan_est[1];
  assign bypass_corrector_ch_b = chan_byp[1];
endmodule

// *** verif/occ_sva.sv ***
// Checker for the offset corrector control bank
`timescale 1ns/1ps
module occ_sva (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Channel controls
  input wire occ_pkg::occ_mode_t mode_ch_a,
  input wire logic estimate_en_ch_a,
  input wire logic bypass_corrector_ch_a,
  input wire occ_pkg::occ_mode_t mode_ch_b,
  input wire logic estimate_en_ch_b,
  input wire logic bypass_corrector_ch_b
);
  import occ_pkg::*;
  // Flags and mode register together, so same-cycle checks
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_frz_a; mode_ch_a == OCC_MODE_FREEZE |-> !estimate_en_ch_a && !bypass_corrector_ch_a; endproperty
  a_frz_a: assert property (p_frz_a) else $error("a frozen yet busy");
  property p_frz_b; mode_ch_b == OCC_MODE_FREEZE |-> !estimate_en_ch_b && !bypass_corrector_ch_b; endproperty
  a_frz_b: assert property (p_frz_b) else $error("b frozen yet busy");
  property p_byp_a; bypass_corrector_ch_a |-> mode_ch_a == OCC_MODE_OFF && !estimate_en_ch_a; endproperty
  a_byp_a: assert property (p_byp_a) else $error("a bypass not off");
  property p_byp_b; bypass_corrector_ch_b |-> mode_ch_b == OCC_MODE_OFF && !estimate_en_ch_b; endproperty
  a_byp_b: assert property (p_byp_b) else $error("b bypass not off");
  property p_run_a; !bypass_corrector_ch_a && mode_ch_a != OCC_MODE_FREEZE
    |-> mode_ch_a == OCC_MODE_RUN && estimate_en_ch_a; endproperty
  a_run_a: assert property (p_run_a) else $error("a not running");
  property p_run_b; !bypass_corrector_ch_b && mode_ch_b != OCC_MODE_FREEZE
    |-> mode_ch_b == OCC_MODE_RUN && estimate_en_ch_b; endproperty
  a_run_b: assert property (p_run_b) else $error("b not running");
  c_frz: cover property (mode_ch_a == OCC_MODE_FREEZE);
  c_byp: cover property (bypass_corrector_ch_a);
  c_frz_b: cover property (mode_ch_b == OCC_MODE_FREEZE);
endmodule
bind occ_ctrl_top occ_sva u_sva (
  .clock(clock),
  .sys_rst(sys_rst),
  .mode_ch_a(mode_ch_a),
  .estimate_en_ch_a(estimate_en_ch_a),
  .bypass_corrector_ch_a(bypass_corrector_ch_a),
  .mode_ch_b(mode_ch_b),
  .estimate_en_ch_b(estimate_en_ch_b),
  .bypass_corrector_ch_b(bypass_corrector_ch_b)
);

// *** verif/tb.sv ***
// Self-checking bench for the offset corrector control bank
`timescale 1ns/1ps
module tb;
  import occ_pkg::*;
  localparam logic [3:0] RUN = {OCC_MODE_RUN, 2'h2};
  localparam logic [3:0] FRZ = {OCC_MODE_FREEZE, 2'h0};
  localparam logic [3:0] OFF = {OCC_MODE_OFF, 2'h1};
  logic clock = 1'b0, sys_rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic estimate_en_ch_a, estimate_en_ch_b, bypass_corrector_ch_a, bypass_corrector_ch_b;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  occ_mode_t mode_ch_a, mode_ch_b;
  int fail_count = 0, tests_run = 0;
  occ_ctrl_top dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .mode_ch_a(mode_ch_a),
    .estimate_en_ch_a(estimate_en_ch_a),
    .bypass_corrector_ch_a(bypass_corrector_ch_a),
    .mode_ch_b(mode_ch_b),
    .estimate_en_ch_b(estimate_en_ch_b),
    .bypass_corrector_ch_b(bypass_corrector_ch_b)
  );
  initial forever #50 clock = ~clock;
  task print_verdict;
    $display("mismatches %0d of %0d checks", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ready sampled at negedge: it only moves on rising edges
  task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = OCC_RESP_OKAY);
    logic aw, w, b;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clock);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid;
      if (b) chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge clock);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    // One edge between transfers so no signal is assigned twice in a step
    @(posedge clock);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = OCC_RESP_OKAY);
    logic ar, r;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge clock);
      ar = s_axi_arvalid & s_axi_arready;
      r = s_axi_rvalid;
      if (r) chk("rdata", {24'h00_0000, d}, s_axi_rdata);
      if (r) chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      @(posedge clock);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task chm(input logic [3:0] ea, input logic [3:0] eb);
    @(negedge clock);
    chk("ch_a", {28'h0, ea}, {28'h0, mode_ch_a, estimate_en_ch_a, bypass_corrector_ch_a});
    chk("ch_b", {28'h0, eb}, {28'h0, mode_ch_b, estimate_en_ch_b, bypass_corrector_ch_b});
    @(posedge clock);
  endtask
  task t_reset;
    chm(RUN, RUN);
    rd(OCC_ADDR_CH_A, 8'h00);
    rd(OCC_ADDR_CH_B, 8'h00);
    // First program after power-up is the running pattern on both pages
    wr(OCC_ADDR_CH_A, 8'h22);
    wr(OCC_ADDR_CH_B, 8'h22);
    chm(RUN, RUN);
    rd(OCC_ADDR_CH_A, 8'h22);
  endtask
  task t_freeze;
    wr(OCC_ADDR_CH_A, 8'hA2);
    chm(FRZ, RUN);
  endtask
  // Legal patterns with bypass on and off; the last pass leaves channel B frozen
  task t_pattern;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {i[0], 1'b0, 1'b1, 2'h0, ~i[1], 1'b1, 1'b0};
      wr(OCC_ADDR_CH_B, d);
      chm(FRZ, i[1] ? (i[0] ? FRZ : RUN) : OFF);
      rd(OCC_ADDR_CH_B, d);
    end
  endtask
  task t_bypass;
    wr(OCC_ADDR_CH_A, 8'hA6);
    chm(OFF, FRZ);
    rd(OCC_ADDR_CH_A, 8'hA6);
    wr(OCC_ADDR_CH_A, 8'h26);
    chm(OFF, FRZ);
    wr(OCC_ADDR_CH_A, 8'h22);
    chm(RUN, FRZ);
  endtask
  task t_unmapped;
    wr(12'h06C, 8'hA6, OCC_RESP_SLVERR);
    rd(12'h200, 8'h00, OCC_RESP_SLVERR);
    // Byte lane 0 off: the write is answered but nothing is stored
    s_axi_wstrb <= 4'h0;
    wr(OCC_ADDR_CH_A, 8'hA2);
    s_axi_wstrb <= 4'h1;
    chm(RUN, FRZ);
    rd(OCC_ADDR_CH_A, 8'h22);
  endtask
  initial begin
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset;
    t_freeze;
    t_pattern;
    t_bypass;
    t_unmapped;
    print_verdict;
  end
  // About 100 cycles expected; allow thirty times that
  initial begin
    #300_000;
    fail_count++;
    print_verdict;
  end
endmodule
